// ### design/eba_params.svh
// constants of the backplane alignment and transmit input port
`ifndef EBA_PARAMS_SVH
`define EBA_PARAMS_SVH

`define EBA_LINK_COUNT      4
`define EBA_RX_FRAME_BITS   256
`define EBA_MUX_FRAME_BITS  2048
`define EBA_RX_POS_W        8
`define EBA_MUX_POS_W       11
`define EBA_LANE_SEL_W      2
`define EBA_RX_POS_RESET    8'h00
`define EBA_MUX_POS_RESET   11'h000

`endif

// ### design/eba_pkg.sv
// types shared by the backplane alignment and transmit input port
`include "eba_params.svh"

package eba_pkg;

  typedef enum logic {
    EBA_MODE_SEPARATE,
    EBA_MODE_MUXED
  } eba_mode_e;

  // one bit handed to a link, with its one-cycle strobe
  typedef struct packed {
    logic data;
    logic valid;
  } eba_bit_s;

  typedef logic [`EBA_MUX_POS_W-1:0] eba_pos_t;

endpackage

// ### design/eba_edge_sampler.sv
// two-stage sampler of a link clock and its data, strobing on rising edges
module eba_edge_sampler #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         linkClock,
  input  wire logic [W-1:0] linkData,
  output logic              edgeSeen,
  output logic [W-1:0]      sampledData
);

  typedef struct packed {
    logic         clkMeta;
    logic         clkSync;
    logic         clkPrev;
    logic [W-1:0] dataMeta;
    logic [W-1:0] dataSync;
    logic         edgeSeen;
    logic [W-1:0] data;
  } eba_smp_state_s;

  eba_smp_state_s state_reg;
  eba_smp_state_s state_next;

  if (W < 1) begin : g_bad_width
    $error("eba_edge_sampler: W must be at least 1");
  end

  always_comb begin
    state_next          = state_reg;
    // first stages feed only the second stages
    state_next.clkMeta  = linkClock;
    state_next.clkSync  = state_reg.clkMeta;
    state_next.clkPrev  = state_reg.clkSync;
    state_next.dataMeta = linkData;
    state_next.dataSync = state_reg.dataMeta;
    state_next.edgeSeen = state_reg.clkSync & ~state_reg.clkPrev;
    // data delayed as much as the clock, so it is taken at the link edge
    if (state_reg.clkSync & ~state_reg.clkPrev) begin
      state_next.data = state_reg.dataSync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign edgeSeen    = state_reg.edgeSeen;
  assign sampledData = state_reg.data;

endmodule // eba_edge_sampler

// ### design/eba_align_port.sv
// backplane frame alignment and transmit data input port of four links
`include "eba_params.svh"

// Functional notes
// - in separate mode one common receive frame pulse aligns the receive data of all four links.
// - in multiplexed mode the multiplexed frame pulse aligns all four links so they can be bit-interleaved.
// - in separate single-rail mode each link's data is taken on the rising edge of its own transmit clock.
// - in separate dual-rail mode each link's positive rail is taken on its transmit clock and goes straight to the jitter attenuator.
// - multiplexed transmit data shares the first link's data pin and links two to four are ignored in multiplexed mode.
// - in multiplexed mode one interleaved stream is taken on the multiplexed transmit clock and aligned by its frame pulse.
// - in multiplexed mode the multiplexed frame pulse is taken on the rising edge of the multiplexed receive clock.
module eba_align_port #(
  parameter int LINKS = `EBA_LINK_COUNT
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      multiplexEnableN,
  input  wire logic                      dualRailSelect,
  input  wire logic                      backplaneRxClock,
  input  wire logic                      backplaneRxFramePulse,
  input  wire logic                      muxedRxClock,
  input  wire logic                      muxedRxFramePulse,
  input  wire logic [LINKS-1:0]          txBackplaneClock,
  input  wire logic [LINKS-1:0]          txPcmInput,
  input  wire logic [LINKS-1:0]          txPositiveRailInput,
  input  wire logic                      muxedTxClock,
  input  wire logic                      muxedTxFramePulse,
  output eba_pkg::eba_mode_e             portMode,
  output logic                           rxFrameStart,
  output eba_pkg::eba_pos_t              rxBitPosition,
  output logic                           txFrameStart,
  output eba_pkg::eba_pos_t              txMuxPosition,
  output eba_pkg::eba_bit_s [LINKS-1:0]  txLane,
  output eba_pkg::eba_bit_s [LINKS-1:0]  jitterAttenuatorLane
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic                          modeMeta;
    logic                          modeSync;
    logic                          rxPulsePrev;
    eba_pkg::eba_mode_e            mode;
    logic                          rxFrameStart;
    eba_pkg::eba_pos_t             rxPos;
    logic                          txFrameStart;
    eba_pkg::eba_pos_t             txPos;
    eba_pkg::eba_bit_s [LINKS-1:0] tx;
    eba_pkg::eba_bit_s [LINKS-1:0] jat;
  } eba_port_state_s;

  eba_port_state_s state_reg;
  eba_port_state_s state_next;

  if (LINKS != `EBA_LINK_COUNT) begin : g_bad_links
    $error("eba_align_port: interleave serves exactly four links");
  end

  // wrap a frame position at the given frame length
  function automatic eba_pkg::eba_pos_t advancePos(
    input eba_pkg::eba_pos_t pos,
    input int unsigned       frameBits
  );
    if (32'(pos) >= frameBits - 1) begin
      advancePos = `EBA_MUX_POS_RESET;
    end else begin
      advancePos = eba_pkg::eba_pos_t'(pos + 11'h001);
    end
  endfunction

  // ***************************************************************
  // link samplers
  // ***************************************************************
  logic             brEdge;
  logic             brPulse;
  logic             mrEdge;
  logic             mrPulse;
  logic             mtEdge;
  logic [1:0]       mtSample;
  logic [LINKS-1:0] btEdge;
  logic [1:0]       btSample [LINKS];

  eba_edge_sampler #(.W(1)) u_br_sampler (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .linkClock   (backplaneRxClock),
    .linkData    (backplaneRxFramePulse),
    .edgeSeen    (brEdge),
    .sampledData (brPulse)
  );

  eba_edge_sampler #(.W(1)) u_mr_sampler (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .linkClock   (muxedRxClock),
    .linkData    (muxedRxFramePulse),
    .edgeSeen    (mrEdge),
    .sampledData (mrPulse)
  );

  // muxed transmit data arrives on the first link's data pin
  eba_edge_sampler #(.W(2)) u_mt_sampler (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .linkClock   (muxedTxClock),
    .linkData    ({muxedTxFramePulse, txPcmInput[0]}),
    .edgeSeen    (mtEdge),
    .sampledData (mtSample)
  );

  genvar gi;
  generate
    for (gi = 0; gi < LINKS; gi++) begin : g_link
      eba_edge_sampler #(.W(2)) u_bt_sampler (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .linkClock   (txBackplaneClock[gi]),
        .linkData    ({txPositiveRailInput[gi], txPcmInput[gi]}),
        .edgeSeen    (btEdge[gi]),
        .sampledData (btSample[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // next state
  // ***************************************************************
  logic [`EBA_LANE_SEL_W-1:0] laneSel;

  always_comb begin
    state_next          = state_reg;
    laneSel             = state_reg.txPos[`EBA_LANE_SEL_W-1:0];
    state_next.modeMeta = multiplexEnableN;
    state_next.modeSync = state_reg.modeMeta;
    state_next.mode     = state_reg.modeSync ? eba_pkg::EBA_MODE_SEPARATE
                                             : eba_pkg::EBA_MODE_MUXED;
    state_next.rxFrameStart = 1'b0;
    state_next.txFrameStart = 1'b0;
    for (int i = 0; i < LINKS; i++) begin
      state_next.tx[i].valid  = 1'b0;
      state_next.jat[i].valid = 1'b0;
    end

    case (state_reg.mode)
      eba_pkg::EBA_MODE_SEPARATE: begin
        // gapped clock only pauses the count, edges alone advance it
        if (brEdge) begin
          state_next.rxPulsePrev = brPulse;
          // pulse may span cycles, so only its leading edge aligns
          if (brPulse && !state_reg.rxPulsePrev) begin
            state_next.rxPos        = `EBA_MUX_POS_RESET;
            state_next.rxFrameStart = 1'b1;
          end else begin
            state_next.rxPos = advancePos(state_reg.rxPos,
                                          `EBA_RX_FRAME_BITS);
            state_next.rxFrameStart =
              (advancePos(state_reg.rxPos, `EBA_RX_FRAME_BITS)
               == `EBA_MUX_POS_RESET);
          end
        end
        for (int i = 0; i < LINKS; i++) begin
          if (btEdge[i]) begin
            if (dualRailSelect) begin
              state_next.jat[i].data  = btSample[i][1];
              state_next.jat[i].valid = 1'b1;
            end else begin
              state_next.tx[i].data  = btSample[i][0];
              state_next.tx[i].valid = 1'b1;
            end
          end
        end
      end
      eba_pkg::EBA_MODE_MUXED: begin
        // none of the four lane samplers is read here
        if (mrEdge) begin
          if (mrPulse) begin
            state_next.rxPos        = `EBA_MUX_POS_RESET;
            state_next.rxFrameStart = 1'b1;
          end else begin
            state_next.rxPos = advancePos(state_reg.rxPos,
                                          `EBA_MUX_FRAME_BITS);
            state_next.rxFrameStart =
              (advancePos(state_reg.rxPos, `EBA_MUX_FRAME_BITS)
               == `EBA_MUX_POS_RESET);
          end
        end
        if (mtEdge) begin
          if (mtSample[1]) begin
            laneSel                 = '0;
            state_next.txPos        = 11'h001;
            state_next.txFrameStart = 1'b1;
          end else begin
            state_next.txPos = advancePos(state_reg.txPos,
                                          `EBA_MUX_FRAME_BITS);
          end
          state_next.tx[laneSel].data  = mtSample[0];
          state_next.tx[laneSel].valid = 1'b1;
        end
      end
      default: begin
        state_next.mode = eba_pkg::EBA_MODE_SEPARATE;
      end
    endcase

    // a change of mode restarts both frame counts
    if (state_next.mode != state_reg.mode) begin
      state_next.rxPos = `EBA_MUX_POS_RESET;
      state_next.txPos = `EBA_MUX_POS_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg          <= '0;
      // mode synchroniser starts at the idle separate level, no blip
      state_reg.modeMeta <= 1'b1;
      state_reg.modeSync <= 1'b1;
      state_reg.mode     <= eba_pkg::EBA_MODE_SEPARATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign portMode             = state_reg.mode;
  assign rxFrameStart         = state_reg.rxFrameStart;
  assign rxBitPosition        = state_reg.rxPos;
  assign txFrameStart         = state_reg.txFrameStart;
  assign txMuxPosition        = state_reg.txPos;
  assign txLane               = state_reg.tx;
  assign jitterAttenuatorLane = state_reg.jat;

endmodule // eba_align_port

// ### test/eba_align_port_properties.sv
// timing relations of the alignment port, with its bind
module eba_align_checker #(
  parameter int LINKS = 4
) (
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic                          dualRailSelect,
  input wire logic                          backplaneRxClock,
  input wire logic [LINKS-1:0]              txPcmInput,
  input wire logic [LINKS-1:0]              txPositiveRailInput,
  input wire eba_pkg::eba_mode_e            portMode,
  input wire logic                          rxFrameStart,
  input wire eba_pkg::eba_pos_t             rxBitPosition,
  input wire logic                          txFrameStart,
  input wire eba_pkg::eba_pos_t             txMuxPosition,
  input wire eba_pkg::eba_bit_s [LINKS-1:0] txLane,
  input wire eba_pkg::eba_bit_s [LINKS-1:0] jitterAttenuatorLane
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // checks
  // ****
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire logic sepMode = (portMode == eba_pkg::EBA_MODE_SEPARATE);

  a_rx_follows: assert property (
    $rose(backplaneRxClock) && sepMode |->
      ##[2:6] ($changed(rxBitPosition) || rxFrameStart))
    else $error("rx position missed a clock edge");
  a_rx_wraps: assert property (
    sepMode && $past(sepMode) && $changed(rxBitPosition) |->
      rxBitPosition == 11'h000 ||
      rxBitPosition == (($past(rxBitPosition) + 11'h001) & 11'h0ff))
    else $error("separate rx position stepped wrongly");
  a_mux_steps: assert property (
    !sepMode && !$past(sepMode) && $changed(rxBitPosition) |->
      rxBitPosition == 11'h000 ||
      rxBitPosition == $past(rxBitPosition) + 11'h001)
    else $error("muxed rx position stepped wrongly");
  a_start_zero: assert property (
    rxFrameStart |-> rxBitPosition == 11'h000)
    else $error("frame start away from position zero");
  a_tx_start: assert property (
    txFrameStart |-> txMuxPosition == 11'h001 && txLane[0].valid)
    else $error("muxed frame pulse did not restart lane zero");
  // 3 cycles back lands where the data stood still around the edge
  a_pcm_taken: assert property (
    txLane[0].valid && sepMode && !dualRailSelect |->
      txLane[0].data == $past(txPcmInput[0], 3))
    else $error("lane data is not the sampled pcm bit");
  a_rail_taken: assert property (
    jitterAttenuatorLane[0].valid |->
      jitterAttenuatorLane[0].data == $past(txPositiveRailInput[0], 3))
    else $error("bypass data is not the sampled rail bit");
  a_mux_no_rail: assert property (
    !sepMode && !$past(sepMode, 6) |-> !jitterAttenuatorLane[1].valid &&
      !jitterAttenuatorLane[2].valid && !jitterAttenuatorLane[3].valid)
    else $error("a link rail strobed in muxed mode");
endmodule // eba_align_checker

bind eba_align_port eba_align_checker #(.LINKS(LINKS)) i_chk (
  .ref_clk, .rst, .dualRailSelect, .backplaneRxClock, .txPcmInput,
  .txPositiveRailInput, .portMode, .rxFrameStart, .rxBitPosition,
  .txFrameStart, .txMuxPosition, .txLane, .jitterAttenuatorLane);

// ### test/eba_backplane_model.sv
// backplane-side model driving link clocks, data and frame pulses
module eba_backplane_model (
  input  wire logic       ref_clk,
  output wire logic       backplaneRxClock,
  output wire logic       backplaneRxFramePulse,
  output wire logic       muxedRxClock,
  output wire logic       muxedRxFramePulse,
  output wire logic [3:0] txBackplaneClock,
  output wire logic [3:0] txPcmInput,
  output wire logic [3:0] txPositiveRailInput,
  output wire logic       muxedTxClock,
  output wire logic       muxedTxFramePulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // link drivers
  // ****
  // channel 0-3 lanes, 4 rx, 5 muxed rx, 6 muxed tx on lane 0 data
  logic [6:0] clk = '0;
  logic [6:0] pin = '0;
  assign {muxedTxClock, muxedRxClock, backplaneRxClock} = clk[6:4];
  assign {muxedTxFramePulse, muxedRxFramePulse} = pin[6:5];
  assign backplaneRxFramePulse = pin[4];
  assign txBackplaneClock = clk[3:0];
  assign txPcmInput = pin[3:0];
  assign txPositiveRailInput = ~pin[3:0];

  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  // changes land on the falling link edge so they stand a half period
  task automatic load(input int ch, input logic d, input logic f);
    if (ch < 4) pin[ch] = d;
    else pin[ch] = f;
    if (ch == 6) pin[0] = d;
    half();
  endtask
  // clock stands low between calls, which also gives a gapped clock
  task automatic pulse(input int ch);
    clk[ch] = 1'b1;
    half();
    clk[ch] = 1'b0;
  endtask
endmodule // eba_backplane_model

// ### test/eba_align_port_tb_top.sv
// self-checking bench of the alignment port against a bench model
module eba_align_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // harness
  // ****
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic multiplexEnableN = 1'b1;
  logic dualRailSelect = 1'b0;
  wire logic backplaneRxClock, backplaneRxFramePulse, muxedRxClock;
  wire logic muxedRxFramePulse, muxedTxClock, muxedTxFramePulse;
  wire logic [3:0] txBackplaneClock, txPcmInput, txPositiveRailInput;
  eba_pkg::eba_mode_e portMode;
  logic rxFrameStart, txFrameStart;
  eba_pkg::eba_pos_t rxBitPosition, txMuxPosition;
  eba_pkg::eba_bit_s [3:0] txLane, jitterAttenuatorLane;
  int n_errors = 0;
  int compares = 0;
  int rxPos = 0, txPos = 0, prevF = 0, muxed = 0;
  int expCnt[10] = '{default: 0};
  int seenCnt[10] = '{default: 0};

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      seenCnt[i] += txLane[i].valid;
      seenCnt[i + 4] += jitterAttenuatorLane[i].valid;
    end
    seenCnt[8] += rxFrameStart;
    seenCnt[9] += txFrameStart;
  end

  eba_align_port i_eba_align_port (.ref_clk, .rst, .multiplexEnableN,
    .dualRailSelect, .backplaneRxClock, .backplaneRxFramePulse,
    .muxedRxClock, .muxedRxFramePulse, .txBackplaneClock, .txPcmInput,
    .txPositiveRailInput, .muxedTxClock, .muxedTxFramePulse, .portMode,
    .rxFrameStart, .rxBitPosition, .txFrameStart, .txMuxPosition, .txLane,
    .jitterAttenuatorLane);
  eba_backplane_model bpModel (.ref_clk, .backplaneRxClock,
    .backplaneRxFramePulse, .muxedRxClock, .muxedRxFramePulse,
    .txBackplaneClock, .txPcmInput, .txPositiveRailInput, .muxedTxClock,
    .muxedTxFramePulse);

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic expect_bit(input int ch, input logic d, input logic f);
    int ln;
    if (!muxed && ch < 4) begin
      expCnt[dualRailSelect ? ch + 4 : ch]++;
      if (dualRailSelect) begin
        chk("rail", !d, jitterAttenuatorLane[ch].data);
      end else begin
        chk("lane", d, txLane[ch].data);
      end
    end
    if (ch == 4 || ch == 5) begin
      // separate mode aligns on the leading edge, muxed on the level
      rxPos = (f && (ch == 5 || !prevF)) ? 0 :
              (rxPos + 1) % (ch == 4 ? 256 : 2048);
      prevF = f;
      if (rxPos == 0) expCnt[8]++;
      chk("rxpos", rxPos, rxBitPosition);
    end
    if (ch == 6) begin
      if (f) begin
        txPos = 0;
        expCnt[9]++;
      end
      ln = txPos % 4;
      expCnt[ln]++;
      txPos = (txPos + 1) % 2048;
      chk("txlane", d, txLane[ln].data);
      chk("txpos", txPos, txMuxPosition);
    end
  endtask

  // n random bits; frame pulse on bits at to at+w-1, data line inverted after the last bit
  task automatic run(input int ch, input int n, input int at, input int w);
    logic d, f, nd, nf;
    d = 1'($urandom);
    f = (at == 0);
    bpModel.load(ch, d, f);
    for (int i = 1; i <= n; i++) begin
      nd = (i < n) ? 1'($urandom) : ~d;
      nf = (i >= at) && (i < at + w);
      bpModel.pulse(ch);
      bpModel.load(ch, nd, nf);
      expect_bit(ch, d, f);
      d = nd;
      f = nf;
    end
  endtask

  initial begin
    #(40 * 40000);
    n_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hec55_7c26));
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    // mode must read separate from the first edge after release
    repeat (4) begin
      @(posedge ref_clk);
      #1 chk("mode", eba_pkg::EBA_MODE_SEPARATE, portMode);
    end
    for (int c = 0; c < 4; c++) run(c, 5, 99, 0);
    dualRailSelect = 1'b1;
    for (int c = 0; c < 4; c++) run(c, 5, 99, 0);
    dualRailSelect = 1'b0;
    run(4, 300, 40, 2);
    repeat (20) @(posedge ref_clk);
    #1 run(4, 7, 6, 1);
    multiplexEnableN = 1'b0;
    muxed = 1;
    // a change of mode restarts both frame counts
    rxPos = 0;
    txPos = 0;
    repeat (8) @(posedge ref_clk);
    #1 chk("mode", eba_pkg::EBA_MODE_MUXED, portMode);
    for (int c = 1; c < 4; c++) run(c, 4, 99, 0);
    // rail select must not wake the unused links either
    dualRailSelect = 1'b1;
    for (int c = 1; c < 4; c++) run(c, 4, 99, 0);
    dualRailSelect = 1'b0;
    run(5, 2100, 10, 1);
    run(6, 40, 0, 1);
    run(6, 9, 99, 0);
    for (int i = 0; i < 10; i++) chk("count", expCnt[i], seenCnt[i]);
    end_of_test();
  end
endmodule // eba_align_port_tb_top
